// >>> shared/clk_mux_pkg.sv
package clk_mux_pkg;

  // register offsets
  localparam logic [7:0] OFS_SYNTH_FREQ_REGION       = 8'h38;
  localparam logic [7:0] OFS_SYNTH_FREQ_CONTROL      = 8'h39;
  localparam logic [7:0] OFS_PORT_TWO_FREQ_SELECT    = 8'h60;
  localparam logic [7:0] OFS_PORT_THREE_FREQ_SELECT  = 8'h61;
  localparam logic [7:0] OFS_PORT_ONE_FOUR_FREQ_SEL  = 8'h62;
  localparam logic [7:0] OFS_SYNC_OUTPUT_DISABLE     = 8'h63;
  localparam logic [7:0] OFS_SYNC_SHAPE_CONTROL      = 8'h7a;

  // reset values
  localparam logic [7:0] RST_REG                     = 8'h00;

  // field positions
  localparam int POS_PORT_ONE_SEL   = 4;
  localparam int POS_PORT_TWO_SEL   = 4;
  localparam int POS_PORT_THREE_SEL = 0;
  localparam int POS_PORT_FOUR_SEL  = 0;
  localparam int POS_SYNTH_A_CTL    = 4;
  localparam int POS_SYNTH_B_CTL    = 6;
  localparam int POS_SYNTH_A_REGION = 5;
  localparam int POS_SYNTH_B_REGION = 6;
  localparam int POS_FRAME_DISABLE  = 7;
  localparam int POS_MFRAME_DISABLE = 6;
  localparam int POS_SYNC_FROM_AUX  = 7;
  localparam int POS_SHAPE_8K       = 2;
  localparam int POS_SHAPE_2K       = 0;
  localparam int SHAPE_BIT_PULSE    = 0;
  localparam int SHAPE_BIT_INVERT   = 1;

  // output frequency selector codes
  localparam logic [3:0] CODE_OFF     = 4'h0;
  localparam logic [3:0] CODE_2K      = 4'h1;
  localparam logic [3:0] CODE_8K      = 4'h2;
  localparam logic [3:0] CODE_SPECIAL = 4'h3;
  localparam logic [3:0] CODE_SYNTH_A = 4'h4;
  localparam logic [3:0] CODE_M_48    = 4'h5;
  localparam logic [3:0] CODE_M_16    = 4'h6;
  localparam logic [3:0] CODE_M_12    = 4'h7;
  localparam logic [3:0] CODE_M_8     = 4'h8;
  localparam logic [3:0] CODE_M_6     = 4'h9;
  localparam logic [3:0] CODE_M_4     = 4'ha;
  localparam logic [3:0] CODE_A_64    = 4'hb;
  localparam logic [3:0] CODE_A_48    = 4'hc;
  localparam logic [3:0] CODE_A_16    = 4'hd;
  localparam logic [3:0] CODE_A_8     = 4'he;
  localparam logic [3:0] CODE_A_4     = 4'hf;

  // port indices
  localparam logic [1:0] PORT_ONE   = 2'h0;
  localparam logic [1:0] PORT_TWO   = 2'h1;
  localparam logic [1:0] PORT_THREE = 2'h2;
  localparam logic [1:0] PORT_FOUR  = 2'h3;

  // main path divider taps
  localparam int M_DIV1 = 0, M_DIV2 = 1, M_DIV4 = 2, M_DIV6 = 3;
  localparam int M_DIV8 = 4, M_DIV12 = 5, M_DIV16 = 6, M_DIV48 = 7;
  // aux path divider taps
  localparam int A_DIV2 = 0, A_DIV4 = 1, A_DIV8 = 2, A_DIV16 = 3, A_DIV48 = 4, A_DIV64 = 5;

  // sync generator indices
  localparam int SY_MAIN_8K = 0, SY_MAIN_2K = 1, SY_SEL_8K = 2, SY_SEL_2K = 3;

  // synthesizer figures in kHz
  localparam longint DFS_RATE_KHZ = 77760;
  localparam longint SYN_KHZ_E [4] = '{2048, 4096, 8192, 16384};
  localparam longint SYN_KHZ_T [4] = '{1544, 3088, 6176, 12352};
  localparam int     ACC_W        = 32;

endpackage

// >>> design/synth_dfs.sv
`timescale 1ns/1ps
module synth_dfs
  import clk_mux_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // control
  input  wire logic       dfs_tick,
  input  wire logic [1:0] freq_ctl,
  input  wire logic       region,
  // output
  output logic            synth_clk
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } dfs_state_t;

  dfs_state_t s;
  dfs_state_t next_s;
  logic [ACC_W-1:0] inc;

  // increment is frequency over the 77.76 MHz rate, scaled to the accumulator
  always_comb begin
    if (region) begin
      inc = ACC_W'((SYN_KHZ_T[freq_ctl] << ACC_W) / DFS_RATE_KHZ);
    end else begin
      inc = ACC_W'((SYN_KHZ_E[freq_ctl] << ACC_W) / DFS_RATE_KHZ);
    end
  end

  always_comb begin
    next_s = s;
    if (dfs_tick) begin
      next_s.acc = s.acc + inc;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synth_clk = s.acc[ACC_W-1];

  chk_dfs_hold: assert property (@(posedge core_clk) disable iff (reset)
    !dfs_tick |=> $stable(s.acc)) else $error("accumulator moved without tick");

endmodule // synth_dfs

// >>> design/output_clock_select_mux.sv
`timescale 1ns/1ps
module output_clock_select_mux
  import clk_mux_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  // main path sources
  input  wire logic [7:0] main_apll_div,
  input  wire logic       main_sync_8k,
  input  wire logic       main_sync_2k,
  input  wire logic       dfs_tick_77m,
  input  wire logic       dfs_tick_apll,
  input  wire logic       dfs_via_apll,
  // aux path sources
  input  wire logic [5:0] aux_apll_div,
  input  wire logic       aux_sync_8k,
  input  wire logic       aux_sync_2k,
  // outputs
  output logic            output_port_one,
  output logic            output_port_two,
  output logic            output_port_three,
  output logic            output_port_four,
  output logic            frame_sync_out,
  output logic            multiframe_sync_out
);

  typedef struct packed {
    logic [7:0] synth_freq_region;
    logic [7:0] synth_freq_control;
    logic [7:0] port_two_freq_select;
    logic [7:0] port_three_freq_select;
    logic [7:0] port_one_four_freq_select;
    logic [7:0] sync_output_disable;
    logic [7:0] sync_shape_control;
    logic [7:0] rdata;
    logic       rvalid;
    logic [3:0] src_prev;
    logic [3:0] armed;
    logic [3:0] pulse;
    logic [3:0] shaped;
    logic [3:0] port_out;
    logic       p3_prev;
    logic       fs;
    logic       mfs;
  } mux_state_t;

  mux_state_t s;
  mux_state_t next_s;

  logic       dfs_tick;
  logic       synth_freq_a;
  logic       synth_freq_b;
  logic [3:0] sync_src;
  logic [3:0] sel_code [4];
  logic [1:0] shape_8k;
  logic [1:0] shape_2k;
  logic       p3_rise;

  // synth clock from 77M block or via APLL
  assign dfs_tick = dfs_via_apll ? dfs_tick_apll : dfs_tick_77m;

  synth_dfs u_synth_a (
    .core_clk  (core_clk),
    .reset     (reset),
    .dfs_tick  (dfs_tick),
    .freq_ctl  (s.synth_freq_control[POS_SYNTH_A_CTL +: 2]),
    .region    (s.synth_freq_region[POS_SYNTH_A_REGION]),
    .synth_clk (synth_freq_a)
  );

  synth_dfs u_synth_b (
    .core_clk  (core_clk),
    .reset     (reset),
    .dfs_tick  (dfs_tick),
    .freq_ctl  (s.synth_freq_control[POS_SYNTH_B_CTL +: 2]),
    .region    (s.synth_freq_region[POS_SYNTH_B_REGION]),
    .synth_clk (synth_freq_b)
  );

  assign sel_code[PORT_ONE]   = s.port_one_four_freq_select[POS_PORT_ONE_SEL +: 4];
  assign sel_code[PORT_TWO]   = s.port_two_freq_select[POS_PORT_TWO_SEL +: 4];
  assign sel_code[PORT_THREE] = s.port_three_freq_select[POS_PORT_THREE_SEL +: 4];
  assign sel_code[PORT_FOUR]  = s.port_one_four_freq_select[POS_PORT_FOUR_SEL +: 4];

  assign shape_8k = s.sync_shape_control[POS_SHAPE_8K +: 2];
  assign shape_2k = s.sync_shape_control[POS_SHAPE_2K +: 2];

  // frame syncs from main path only
  assign sync_src[SY_MAIN_8K] = main_sync_8k;
  assign sync_src[SY_MAIN_2K] = main_sync_2k;
  // port sync options follow path select
  assign sync_src[SY_SEL_8K]  = s.sync_shape_control[POS_SYNC_FROM_AUX] ? aux_sync_8k : main_sync_8k;
  assign sync_src[SY_SEL_2K]  = s.sync_shape_control[POS_SYNC_FROM_AUX] ? aux_sync_2k : main_sync_2k;

  // pulses are timed by port three edges
  assign p3_rise = s.port_out[PORT_THREE] & ~s.p3_prev;

  function automatic logic pick(input logic [3:0] code, input logic [1:0] port, input logic s2k,
                                input logic s8k, input logic da, input logic db,
                                input logic [7:0] m, input logic [5:0] a);
    logic r;
    r = 1'b0;
    unique case (code)
      CODE_OFF:     r = 1'b0;
      CODE_2K:      r = s2k;
      CODE_8K:      r = s8k;
      CODE_SPECIAL: r = (port == PORT_ONE) ? m[M_DIV2] : db;
      CODE_SYNTH_A: r = da;
      CODE_M_48:    r = (port == PORT_ONE) ? m[M_DIV1] : m[M_DIV48];
      CODE_M_16:    r = m[M_DIV16];
      CODE_M_12:    r = m[M_DIV12];
      CODE_M_8:     r = m[M_DIV8];
      CODE_M_6:     r = m[M_DIV6];
      CODE_M_4:     r = m[M_DIV4];
      CODE_A_64:    r = (port == PORT_FOUR) ? a[A_DIV2] : a[A_DIV64];
      CODE_A_48:    r = a[A_DIV48];
      CODE_A_16:    r = a[A_DIV16];
      CODE_A_8:     r = a[A_DIV8];
      CODE_A_4:     r = a[A_DIV4];
    endcase
    return r;
  endfunction

  always_comb begin
    logic [1:0] mode;
    mode   = 2'h0;
    next_s = s;
    next_s.rvalid = 1'b0;

    // register writes; unmapped offsets are ignored
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_SYNTH_FREQ_REGION:      next_s.synth_freq_region = reg_wdata;
        OFS_SYNTH_FREQ_CONTROL:     next_s.synth_freq_control = reg_wdata;
        OFS_PORT_TWO_FREQ_SELECT:   next_s.port_two_freq_select = reg_wdata;
        OFS_PORT_THREE_FREQ_SELECT: next_s.port_three_freq_select = reg_wdata;
        OFS_PORT_ONE_FOUR_FREQ_SEL: next_s.port_one_four_freq_select = reg_wdata;
        OFS_SYNC_OUTPUT_DISABLE:    next_s.sync_output_disable = reg_wdata;
        OFS_SYNC_SHAPE_CONTROL:     next_s.sync_shape_control = reg_wdata;
        default: ;
      endcase
    end

    // register reads answer one cycle later, zero when unmapped
    if (reg_rd) begin
      next_s.rvalid = 1'b1;
      unique case (reg_addr)
        OFS_SYNTH_FREQ_REGION:      next_s.rdata = s.synth_freq_region;
        OFS_SYNTH_FREQ_CONTROL:     next_s.rdata = s.synth_freq_control;
        OFS_PORT_TWO_FREQ_SELECT:   next_s.rdata = s.port_two_freq_select;
        OFS_PORT_THREE_FREQ_SELECT: next_s.rdata = s.port_three_freq_select;
        OFS_PORT_ONE_FOUR_FREQ_SEL: next_s.rdata = s.port_one_four_freq_select;
        OFS_SYNC_OUTPUT_DISABLE:    next_s.rdata = s.sync_output_disable;
        OFS_SYNC_SHAPE_CONTROL:     next_s.rdata = s.sync_shape_control;
        default:                    next_s.rdata = 8'h00;
      endcase
    end

    // sync shaping per generator
    next_s.src_prev = sync_src;
    next_s.p3_prev  = s.port_out[PORT_THREE];
    for (int i = 0; i < 4; i++) begin
      mode = ((i == SY_MAIN_8K) || (i == SY_SEL_8K)) ? shape_8k : shape_2k;
      // pulse starts and ends on port three rising edges
      if (p3_rise) begin
        next_s.pulse[i] = s.armed[i];
        next_s.armed[i] = 1'b0;
      end
      // a new sync edge wins over the disarm
      if (sync_src[i] & ~s.src_prev[i]) begin
        next_s.armed[i] = 1'b1;
      end
      // clock keeps source duty, either form inverts
      next_s.shaped[i] = (mode[SHAPE_BIT_PULSE] ? s.pulse[i] : sync_src[i]) ^ mode[SHAPE_BIT_INVERT];
    end

    next_s.fs  = s.shaped[SY_MAIN_8K] & ~s.sync_output_disable[POS_FRAME_DISABLE];
    next_s.mfs = s.shaped[SY_MAIN_2K] & ~s.sync_output_disable[POS_MFRAME_DISABLE];

    // each port muxed by its own selector
    for (int p = 0; p < 4; p++) begin
      next_s.port_out[p] = pick(sel_code[p], 2'(p), s.shaped[SY_SEL_2K], s.shaped[SY_SEL_8K],
                                synth_freq_a, synth_freq_b, main_apll_div, aux_apll_div);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.synth_freq_region         <= RST_REG;
      s.synth_freq_control        <= RST_REG;
      s.port_two_freq_select      <= RST_REG;
      s.port_three_freq_select    <= RST_REG;
      s.port_one_four_freq_select <= RST_REG;
      s.sync_output_disable       <= RST_REG;
      s.sync_shape_control        <= RST_REG;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata           = s.rdata;
  assign reg_rvalid          = s.rvalid;
  assign output_port_one     = s.port_out[PORT_ONE];
  assign output_port_two     = s.port_out[PORT_TWO];
  assign output_port_three   = s.port_out[PORT_THREE];
  assign output_port_four    = s.port_out[PORT_FOUR];
  assign frame_sync_out      = s.fs;
  assign multiframe_sync_out = s.mfs;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence port_one_off;
    sel_code[PORT_ONE] == CODE_OFF;
  endsequence

  chk_port_one_off: assert property (port_one_off ##1 port_one_off |-> !output_port_one)
    else $error("port one not low while off");

  chk_port_one_div1: assert property (sel_code[PORT_ONE] == CODE_M_48 |=>
    output_port_one == $past(main_apll_div[M_DIV1])) else $error("port one not main div 1");

  chk_port_four_div2: assert property (sel_code[PORT_FOUR] == CODE_A_64 |=>
    output_port_four == $past(aux_apll_div[A_DIV2])) else $error("port four not aux div 2");

  chk_port_two_synth_b: assert property (sel_code[PORT_TWO] == CODE_SPECIAL |=>
    output_port_two == $past(synth_freq_b)) else $error("port two not synth b");

  chk_port_three_synth: assert property (sel_code[PORT_THREE] == CODE_SYNTH_A |=>
    output_port_three == $past(synth_freq_a)) else $error("port three not synth a");

  chk_frame_disable: assert property (s.sync_output_disable[POS_FRAME_DISABLE]
    ##1 s.sync_output_disable[POS_FRAME_DISABLE] |-> !frame_sync_out) else $error("frame sync not off");

  chk_frame_main_clk: assert property (shape_8k == 2'h0 && !s.sync_output_disable[POS_FRAME_DISABLE]
    ##1 shape_8k == 2'h0 && !s.sync_output_disable[POS_FRAME_DISABLE]
    |=> frame_sync_out == $past(main_sync_8k, 2)) else $error("frame sync not from main path");

  chk_mframe_inverted: assert property (shape_2k == 2'h2 ##1 shape_2k == 2'h2
    |-> s.shaped[SY_MAIN_2K] == !$past(main_sync_2k)) else $error("multiframe not inverted clock");

  chk_path_select: assert property (s.sync_shape_control[POS_SYNC_FROM_AUX] && shape_8k == 2'h0
    |=> s.shaped[SY_SEL_8K] == $past(aux_sync_8k)) else $error("8k option not from aux path");

  chk_pulse_ends: assert property ((s.pulse[SY_MAIN_8K] && p3_rise && !s.armed[SY_MAIN_8K])
    |=> !s.pulse[SY_MAIN_8K]) else $error("pulse longer than one port three cycle");

  chk_pulse_starts: assert property ((!s.pulse[SY_MAIN_8K] && !p3_rise)
    |=> !s.pulse[SY_MAIN_8K]) else $error("pulse rose off a port three edge");

  chk_pulse_invert: assert property (shape_8k == 2'h3 ##1 shape_8k == 2'h3
    |-> s.shaped[SY_MAIN_8K] == !$past(s.pulse[SY_MAIN_8K])) else $error("8k not inverted pulse");

  chk_read_answer: assert property (reg_rd && reg_addr == OFS_SYNC_SHAPE_CONTROL && !reg_wr
    |=> reg_rvalid && reg_rdata == $past(s.sync_shape_control)) else $error("bad register read");

endmodule // output_clock_select_mux

// >>> dv/clock_sink_model.sv
`timescale 1ns/1ps
module clock_sink_model (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // observed clocks and window restart
  input  wire logic [5:0]       sig,
  input  wire logic             clear,
  // per-window edge and high-time counts
  output logic      [5:0][15:0] rises,
  output logic      [5:0][15:0] highs
);
  logic [5:0] prev;

  // a level already high at window start is not taken as an edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset || clear) begin
      prev  <= '1;
      rises <= '0;
      highs <= '0;
    end else begin
      prev <= sig;
      for (int i = 0; i < 6; i++) begin
        rises[i] <= rises[i] + 16'(sig[i] & ~prev[i]);
        highs[i] <= highs[i] + 16'(sig[i]);
      end
    end
  end
endmodule // clock_sink_model

// >>> dv/output_clock_select_mux_tb_top.sv
`timescale 1ns/1ps
module output_clock_select_mux_tb_top;
  import clk_mux_pkg::*;
  logic             core_clk, reset, reg_wr, reg_rd, reg_rvalid, clear;
  logic             dfs_tick_apll, dfs_via_apll, p1, p2, p3, p4, fs, mfs;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, main_apll_div;
  logic [5:0]       aux_apll_div;
  logic [3:0]       sy;
  logic [5:0][15:0] rises, highs;
  logic [15:0]      agree8, agree2;
  int               cnt = 0;
  int               miscompares = 0;
  int               checks_done = 0;
  int               mh[8] = '{1, 2, 4, 6, 8, 12, 16, 48};
  int               ah[6] = '{3, 5, 7, 9, 10, 14};
  int               sh[4] = '{40, 160, 48, 240};

  // source clocks as half periods of core cycles
  always_comb begin
    for (int i = 0; i < 8; i++) main_apll_div[i] = 1'((cnt / mh[i]) % 2);
    for (int i = 0; i < 6; i++) aux_apll_div[i] = 1'((cnt / ah[i]) % 2);
    for (int i = 0; i < 4; i++) sy[i] = 1'((cnt / sh[i]) % 2);
  end

  always @(negedge core_clk) cnt <= cnt + 1;

  always @(posedge core_clk) begin
    agree8 <= clear ? 16'h0 : agree8 + 16'(fs == sy[0]);
    agree2 <= clear ? 16'h0 : agree2 + 16'(mfs == sy[1]);
  end

  output_clock_select_mux DUT (
    .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .main_apll_div(main_apll_div),
    .main_sync_8k(sy[0]), .main_sync_2k(sy[1]), .dfs_tick_77m(1'b1), .dfs_tick_apll(dfs_tick_apll),
    .dfs_via_apll(dfs_via_apll), .aux_apll_div(aux_apll_div), .aux_sync_8k(sy[2]), .aux_sync_2k(sy[3]),
    .output_port_one(p1), .output_port_two(p2), .output_port_three(p3), .output_port_four(p4),
    .frame_sync_out(fs), .multiframe_sync_out(mfs));

  clock_sink_model sink (
    .core_clk(core_clk), .reset(reset), .sig({mfs, fs, p4, p3, p2, p1}), .clear(clear),
    .rises(rises), .highs(highs));

  task automatic results();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, int lo, int hi, string m);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0d", $time, m, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    checks_done++;
    if (reg_rvalid !== 1'b1 || reg_rdata !== exp) begin
      miscompares++;
      $display("unexpected at %0t: read %h gave %h", $time, a, reg_rdata);
    end
  endtask

  task automatic sel(logic [3:0] a, logic [3:0] b, logic [3:0] c, logic [3:0] d);
    wr(OFS_PORT_ONE_FOUR_FREQ_SEL, {a, d});
    wr(OFS_PORT_TWO_FREQ_SELECT, {b, 4'h0});
    wr(OFS_PORT_THREE_FREQ_SELECT, {4'h0, c});
  endtask

  task automatic meas(int w);
    @(negedge core_clk);
    clear = 1'b1;
    @(negedge core_clk);
    clear = 1'b0;
    repeat (w) @(negedge core_clk);
  endtask

  function automatic int half(int p, int k);
    case (k)
      0: return 0;
      3: return mh[M_DIV2];
      5: return p == 0 ? mh[M_DIV1] : mh[M_DIV48];
      6: return mh[M_DIV16];
      7: return mh[M_DIV12];
      8: return mh[M_DIV8];
      9: return mh[M_DIV6];
      10: return mh[M_DIV4];
      11: return p == 3 ? ah[A_DIV2] : ah[A_DIV64];
      12: return ah[A_DIV48];
      13: return ah[A_DIV16];
      14: return ah[A_DIV8];
      default: return ah[A_DIV4];
    endcase
  endfunction

  task automatic t_regs();
    logic [7:0] ofs[7] = '{OFS_SYNTH_FREQ_REGION, OFS_SYNTH_FREQ_CONTROL, OFS_PORT_TWO_FREQ_SELECT,
      OFS_PORT_THREE_FREQ_SELECT, OFS_PORT_ONE_FOUR_FREQ_SEL, OFS_SYNC_OUTPUT_DISABLE, OFS_SYNC_SHAPE_CONTROL};
    foreach (ofs[i]) rd(ofs[i], RST_REG);
    foreach (ofs[i]) wr(ofs[i], 8'(8'h11 * (i + 1)));
    foreach (ofs[i]) rd(ofs[i], 8'(8'h11 * (i + 1)));
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    foreach (ofs[i]) wr(ofs[i], 8'h00);
  endtask

  task automatic t_codes();
    logic [3:0] c[4];
    int         h;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 16; k++) begin
        if (k >= 1 && k <= 4 && !(k == 3 && p == 0)) continue;
        c = '{default: 4'h0};
        c[p] = 4'(k);
        sel(c[0], c[1], c[2], c[3]);
        meas(480);
        for (int q = 0; q < 4; q++) begin
          h = (q == p) ? half(q, k) : 0;
          chk(rises[q], h ? 240 / h - 1 : 0, h ? 240 / h + 1 : 0, "port source");
        end
      end
    end
  endtask

  task automatic t_synth();
    int fa;
    int fb;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 4; k++) begin
        fa = int'(r ? SYN_KHZ_T[k] : SYN_KHZ_E[k]);
        fb = int'(r ? SYN_KHZ_E[3 - k] : SYN_KHZ_T[3 - k]);
        wr(OFS_SYNTH_FREQ_REGION, 8'((r << POS_SYNTH_A_REGION) | ((1 - r) << POS_SYNTH_B_REGION)));
        wr(OFS_SYNTH_FREQ_CONTROL, 8'((k << POS_SYNTH_A_CTL) | ((3 - k) << POS_SYNTH_B_CTL)));
        sel(4'h0, CODE_SYNTH_A, CODE_SPECIAL, 4'h0);
        meas(1944);
        chk(rises[1], fa / 40 - 2, fa / 40 + 2, "synth a rate");
        chk(rises[2], fb / 40 - 2, fb / 40 + 2, "synth b rate");
      end
    end
    @(negedge core_clk);
    dfs_via_apll = 1'b1;
    meas(480);
    chk(rises[1], 0, 1, "synth runs without its selected tick");
    dfs_tick_apll = 1'b1;
    meas(1944);
    chk(rises[1], fa / 40 - 2, fa / 40 + 2, "synth via apll tick");
    dfs_tick_apll = 1'b0;
    dfs_via_apll = 1'b0;
  endtask

  task automatic t_sync();
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 4; s += 2) begin
        wr(OFS_SYNC_SHAPE_CONTROL, 8'((a << POS_SYNC_FROM_AUX) | (s << POS_SHAPE_8K) | s));
        sel(CODE_2K, CODE_8K, 4'h0, 4'h0);
        meas(1920);
        chk(rises[0], a ? 3 : 5, a ? 5 : 7, "2k port path");
        chk(rises[1], a ? 19 : 23, a ? 21 : 25, "8k port path");
        chk(rises[4], 23, 25, "frame sync path");
        chk(rises[5], 5, 7, "multiframe sync path");
        chk(agree8, s ? 0 : 1700, s ? 220 : 2000, "frame sync polarity");
        chk(agree2, s ? 0 : 1700, s ? 220 : 2000, "multiframe polarity");
        chk(highs[4], 900, 1020, "frame sync duty");
      end
    end
  endtask

  task automatic t_pulse();
    for (int s = 1; s < 4; s += 2) begin
      wr(OFS_SYNC_SHAPE_CONTROL, 8'((s << POS_SHAPE_8K) | s));
      // port three kept well above the pulse minimum
      sel(4'h0, 4'h0, CODE_M_16, 4'h0);
      meas(1920);
      chk(rises[4], 23, 25, "frame pulse count");
      chk(s == 1 ? highs[4] : 16'd1920 - highs[4], 736, 800, "frame pulse width");
      chk(s == 1 ? highs[5] : 16'd1920 - highs[5], 160, 224, "multiframe pulse width");
    end
  endtask

  task automatic t_disable();
    wr(OFS_SYNC_SHAPE_CONTROL, 8'h00);
    for (int d = 1; d < 3; d++) begin
      wr(OFS_SYNC_OUTPUT_DISABLE, 8'(d << POS_MFRAME_DISABLE));
      meas(960);
      chk(rises[4], d == 2 ? 0 : 11, d == 2 ? 0 : 13, "frame sync disable");
      chk(rises[5], d == 1 ? 0 : 2, d == 1 ? 0 : 4, "multiframe disable");
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dfs_tick_apll = 1'b0;
    dfs_via_apll = 1'b0;
    clear = 1'b0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_codes();
    t_synth();
    t_sync();
    t_pulse();
    t_disable();
    results();
  end

  // the full sequence needs roughly 60k cycles
  initial begin
    #900_000;
    miscompares++;
    results();
  end
endmodule // output_clock_select_mux_tb_top
